// ### design/control_channel_i2c_config.sv
`timescale 1ns/100ps
module control_channel_i2c_config
#(
  parameter int WDOG_FAST_CYC = ctrl_channel_pkg::WDOG_FAST_CYC,
  parameter int WDOG_SLOW_CYC = ctrl_channel_pkg::WDOG_SLOW_CYC
)
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire ctrl_channel_pkg::reg_req_s reg_req_i,
  output ctrl_channel_pkg::reg_rsp_s reg_rsp_o,
  input wire logic seq_err_evt_i,
  input wire logic fwd_id_valid_i,
  input wire logic [6:0] fwd_id_i,
  input wire logic host_addr_valid_i,
  input wire logic [6:0] host_addr_i,
  input wire logic [6:0] match_alias_0_i,
  input wire logic [6:0] match_alias_1_i,
  output ctrl_channel_pkg::route_s route_o,
  input wire logic sda_drive_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  output logic bus_free_o,
  output logic bus_recover_o
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic seq_err;
  logic seq_clr;
  logic [1:0] sda_dly_code;
  logic local_wr_block;
  logic timer_fast;
  logic timer_off;
  logic [6:0] remote_addr;
  logic lock_remote_address;
  logic [6:0] target_slave_address_0;
  logic [6:0] target_slave_address_1;
  logic wr_ok;
  logic [7:0] next_rdata;

  // sda delay in cycles for a code, rounded up to whole cycles
  function automatic logic [3:0] sda_delay_cyc(input logic [1:0] code);
    return 4'((ctrl_channel_pkg::SDA_BASE_NS
               + int'(code) * ctrl_channel_pkg::SDA_STEP_NS
               + ctrl_channel_pkg::CLK_PERIOD_NS - 1)
              / ctrl_channel_pkg::CLK_PERIOD_NS);
  endfunction : sda_delay_cyc

  // true when a non-zero alias or address equals the incoming address
  function automatic logic addr_match(input logic [6:0] cfg,
                                      input logic [6:0] addr);
    return (cfg != 7'h00) && (cfg == addr);
  endfunction : addr_match

  // remote side writes are refused only for our own registers; slaves
  // behind us never come through this port, so they stay reachable
  assign wr_ok = reg_req_i.valid && reg_req_i.write
               && !(reg_req_i.remote && local_wr_block);

  // sequence error flag: a new error beats a clear in the same cycle
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      seq_err <=
        ctrl_channel_pkg::RST_ERR_TIMER[ctrl_channel_pkg::BIT_SEQ_ERR];
    else if (seq_err_evt_i)
      seq_err <= 1'b1;
    else if (seq_clr)
      seq_err <= 1'b0;
  end

  // control bits of the error and bus timer register; bit 5 unused
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      seq_clr <= 1'b0;
      sda_dly_code <= 2'h0;
      local_wr_block <= 1'b0;
      timer_fast <= 1'b0;
      timer_off <= 1'b0;
    end
    else if (wr_ok && reg_req_i.addr == ctrl_channel_pkg::ADDR_ERR_TIMER)
    begin
      seq_clr <= reg_req_i.wdata[ctrl_channel_pkg::BIT_SEQ_CLR];
      sda_dly_code <= reg_req_i.wdata[ctrl_channel_pkg::BIT_SDA_DLY_HI:
                                      ctrl_channel_pkg::BIT_SDA_DLY_LO];
      local_wr_block <= reg_req_i.wdata[ctrl_channel_pkg::BIT_LOCAL_WR_BLOCK];
      timer_fast <= reg_req_i.wdata[ctrl_channel_pkg::BIT_TIMER_FAST];
      timer_off <= reg_req_i.wdata[ctrl_channel_pkg::BIT_TIMER_OFF];
    end
  end

  // remote serializer address: a write beats an auto-load in one cycle
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      remote_addr <= ctrl_channel_pkg::RST_REMOTE_SER[7:1];
      lock_remote_address <=
        ctrl_channel_pkg::RST_REMOTE_SER[ctrl_channel_pkg::BIT_LOCK_REMOTE];
    end
    else if (wr_ok && reg_req_i.addr == ctrl_channel_pkg::ADDR_REMOTE_SER)
    begin
      remote_addr <= reg_req_i.wdata[7:1];
      lock_remote_address <=
        reg_req_i.wdata[ctrl_channel_pkg::BIT_LOCK_REMOTE];
    end
    else if (fwd_id_valid_i && !lock_remote_address)
      remote_addr <= fwd_id_i;
  end

  // target slave entries; bit 0 is reserved and never stored
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      target_slave_address_0 <= ctrl_channel_pkg::RST_TARGET[7:1];
      target_slave_address_1 <= ctrl_channel_pkg::RST_TARGET[7:1];
    end
    else if (wr_ok && reg_req_i.addr == ctrl_channel_pkg::ADDR_TARGET_0)
      target_slave_address_0 <= reg_req_i.wdata[7:1];
    else if (wr_ok && reg_req_i.addr == ctrl_channel_pkg::ADDR_TARGET_1)
      target_slave_address_1 <= reg_req_i.wdata[7:1];
  end

  // read mux; reserved bits come back as zero
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (reg_req_i.addr)
      ctrl_channel_pkg::ADDR_ERR_TIMER:
        next_rdata = {seq_err, seq_clr, 1'b0, sda_dly_code,
                      local_wr_block, timer_fast, timer_off};
      ctrl_channel_pkg::ADDR_REMOTE_SER:
        next_rdata = {remote_addr, lock_remote_address};
      ctrl_channel_pkg::ADDR_TARGET_0:
        next_rdata = {target_slave_address_0, 1'b0};
      ctrl_channel_pkg::ADDR_TARGET_1:
        next_rdata = {target_slave_address_1, 1'b0};
      default:
        next_rdata = 8'h00;
    endcase
  end

  // answer one cycle after every request
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      reg_rsp_o <= '0;
    else
    begin
      reg_rsp_o.valid <= reg_req_i.valid;
      reg_rsp_o.hit <= reg_req_i.valid
        && reg_req_i.addr >= ctrl_channel_pkg::ADDR_ERR_TIMER
        && reg_req_i.addr <= ctrl_channel_pkg::ADDR_TARGET_1;
      reg_rsp_o.refused <= reg_req_i.valid && reg_req_i.write
        && reg_req_i.remote && local_wr_block;
      reg_rsp_o.rdata <= (reg_req_i.valid && !reg_req_i.write)
        ? next_rdata : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address routing for local host transactions
  // serializer address first, then alias 0, then alias 1
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      route_o <= '0;
    else
    begin
      route_o.valid <= host_addr_valid_i;
      route_o.to_serializer <= 1'b0;
      route_o.to_slave <= 1'b0;
      route_o.slave_idx <= 1'b0;
      route_o.addr <= host_addr_i;
      if (host_addr_valid_i)
      begin
        if (addr_match(remote_addr, host_addr_i))
          route_o.to_serializer <= 1'b1;
        else if (addr_match(match_alias_0_i, host_addr_i))
        begin
          route_o.to_slave <= 1'b1;
          route_o.addr <= target_slave_address_0;
        end
        else if (addr_match(match_alias_1_i, host_addr_i))
        begin
          route_o.to_slave <= 1'b1;
          route_o.slave_idx <= 1'b1;
          route_o.addr <= target_slave_address_1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sda output delay
  logic [ctrl_channel_pkg::SDA_DLY_MAX_CYC-1:0] sda_line;
  logic [3:0] sda_tap;
  assign sda_tap = sda_delay_cyc(sda_dly_code) - 4'h1;

  // a shift line tapped by the delay code; a live code change can repeat or drop an edge in flight
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sda_line <= '0;
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      sda_line <= {sda_line[ctrl_channel_pkg::SDA_DLY_MAX_CYC-2:0],
                   sda_drive_i};
      sda_oe_o <= sda_line[sda_tap];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus watchdog
  logic [1:0] scl_meta;
  logic [1:0] sda_meta;
  logic scl_prev;
  logic sda_prev;
  logic activity;
  ctrl_channel_pkg::wdog_state_e wd_state;
  logic [ctrl_channel_pkg::WDOG_CNT_W-1:0] idle_cnt;
  logic [ctrl_channel_pkg::WDOG_CNT_W-1:0] idle_lim;
  logic [7:0] half_cnt;
  logic [3:0] pulse_cnt;

  // pins are asynchronous: two flops, then a third for edge finding
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_meta <= {scl_meta[0], scl_i};
      sda_meta <= {sda_meta[0], sda_i};
      scl_prev <= scl_meta[1];
      sda_prev <= sda_meta[1];
    end
  end
  assign activity = (scl_prev != scl_meta[1]) || (sda_prev != sda_meta[1]);
  assign idle_lim = timer_fast
    ? ctrl_channel_pkg::WDOG_CNT_W'(WDOG_FAST_CYC - 1)
    : ctrl_channel_pkg::WDOG_CNT_W'(WDOG_SLOW_CYC - 1);
  // our own scl pulses are not counted as activity while recovering
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wd_state <= ctrl_channel_pkg::WD_WATCH;
      idle_cnt <= '0;
      half_cnt <= 8'h00;
      pulse_cnt <= 4'h0;
      scl_oe_o <= 1'b0;
      scl_o <= 1'b0;
      bus_free_o <= 1'b0;
      bus_recover_o <= 1'b0;
    end
    else
    begin
      unique case (wd_state)
        ctrl_channel_pkg::WD_WATCH:
        begin
          if (timer_off || activity)
          begin
            idle_cnt <= '0;
            bus_free_o <= 1'b0;
          end
          else if (idle_cnt != idle_lim)
            idle_cnt <= idle_cnt + 1'b1;
          else if (sda_prev)
            bus_free_o <= 1'b1;
          else
          begin
            wd_state <= ctrl_channel_pkg::WD_LOW;
            idle_cnt <= '0;
            half_cnt <= 8'h00;
            pulse_cnt <= 4'h0;
            scl_oe_o <= 1'b1;
            bus_recover_o <= 1'b1;
          end
        end
        ctrl_channel_pkg::WD_LOW:
        begin
          if (half_cnt != 8'(ctrl_channel_pkg::SCL_HALF_CYC - 1))
            half_cnt <= half_cnt + 8'h01;
          else
          begin
            half_cnt <= 8'h00;
            scl_oe_o <= 1'b0;
            wd_state <= ctrl_channel_pkg::WD_HIGH;
          end
        end
        ctrl_channel_pkg::WD_HIGH:
        begin
          if (half_cnt != 8'(ctrl_channel_pkg::SCL_HALF_CYC - 1))
            half_cnt <= half_cnt + 8'h01;
          else if (pulse_cnt
                   != 4'(ctrl_channel_pkg::RECOVER_PULSES - 1))
          begin
            half_cnt <= 8'h00;
            pulse_cnt <= pulse_cnt + 4'h1;
            scl_oe_o <= 1'b1;
            wd_state <= ctrl_channel_pkg::WD_LOW;
          end
          else
          begin
            bus_recover_o <= 1'b0;
            wd_state <= ctrl_channel_pkg::WD_WATCH;
          end
        end
        default:
        begin
          wd_state <= ctrl_channel_pkg::WD_WATCH;
          scl_oe_o <= 1'b0;
          bus_recover_o <= 1'b0;
        end
      endcase
    end
  end

endmodule : control_channel_i2c_config

// ### design/ctrl_channel_pkg.sv
// How it works
// - forward channel sequence error sets status flag
// - clear bit wipes flag; software writes zero
// - sda output delay 250ns plus 50ns steps
// - local write block refuses remote register writes
// - remote access to local slaves stays open
// - watchdog period 50ms fast, 1s slow
// - disable bit stops the bus watchdog
// - sda high and idle: bus free
// - sda low and idle: nine scl pulses
// - remote serializer address, zero disables access
// - address auto-loads from forward channel, reset 0x18
// - lock bit freezes the written remote address
// - alias match remaps to target slave address
// - target slave entries at 0x08 and 0x09
// - alias zero disables that remote slave
package ctrl_channel_pkg;

  // register offsets
  localparam logic [7:0] ADDR_ERR_TIMER = 8'h06;
  localparam logic [7:0] ADDR_REMOTE_SER = 8'h07;
  localparam logic [7:0] ADDR_TARGET_0 = 8'h08;
  localparam logic [7:0] ADDR_TARGET_1 = 8'h09;

  // field positions in the error and bus timer register, plus the lock bit of the remote serializer register
  localparam int BIT_SEQ_ERR = 7;
  localparam int BIT_SEQ_CLR = 6;
  localparam int BIT_SDA_DLY_HI = 4;
  localparam int BIT_SDA_DLY_LO = 3;
  localparam int BIT_LOCAL_WR_BLOCK = 2;
  localparam int BIT_TIMER_FAST = 1;
  localparam int BIT_TIMER_OFF = 0;
  localparam int BIT_LOCK_REMOTE = 0;

  // reset values
  localparam logic [7:0] RST_ERR_TIMER = 8'h00;
  localparam logic [7:0] RST_REMOTE_SER = 8'h18;
  localparam logic [7:0] RST_TARGET = 8'h00;

  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SDA_BASE_NS = 250;
  localparam int SDA_STEP_NS = 50;
  localparam int SDA_DLY_MAX_CYC =
    (SDA_BASE_NS + 3 * SDA_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDOG_FAST_MS = 50;
  localparam int WDOG_SLOW_MS = 1000;
  localparam int WDOG_FAST_CYC = WDOG_FAST_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WDOG_SLOW_CYC = WDOG_SLOW_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WDOG_CNT_W = 25;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC = SCL_HALF_NS / CLK_PERIOD_NS;
  localparam int RECOVER_PULSES = 9;

  // register request from the serial control bus slave
  typedef struct packed {
    logic valid;
    logic write;
    logic remote;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // register answer, one cycle after the request
  typedef struct packed {
    logic valid;
    logic hit;
    logic refused;
    logic [7:0] rdata;
  } reg_rsp_s;

  // routing decision for a local host transaction
  typedef struct packed {
    logic valid;
    logic to_serializer;
    logic to_slave;
    logic slave_idx;
    logic [6:0] addr;
  } route_s;

  typedef enum logic [2:0] {
    WD_WATCH = 3'b001,
    WD_LOW = 3'b010,
    WD_HIGH = 3'b100
  } wdog_state_e;

endpackage : ctrl_channel_pkg

// ### verif/ctrl_cfg_props.sv
`timescale 1ns/100ps
module ctrl_cfg_props
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire ctrl_channel_pkg::reg_req_s reg_req_i,
  input wire ctrl_channel_pkg::reg_rsp_s reg_rsp_o,
  input wire logic host_addr_valid_i,
  input wire ctrl_channel_pkg::route_s route_o,
  input wire logic sda_drive_i,
  input wire logic sda_i,
  input wire logic scl_oe_o,
  input wire logic sda_oe_o,
  input wire logic bus_free_o,
  input wire logic bus_recover_o
);
  logic blk;
  logic toff;
  logic [1:0] dly;
  logic wr6;
  assign wr6 = reg_req_i.valid && reg_req_i.write && reg_req_i.addr == 8'h06;
  ////////////////////////////////////////////////////////////////////////////
  // shadow of the control fields; a refused remote write must not move it
  always_ff @(posedge mclk_i or negedge arst_n_i)
    if (!arst_n_i)
      {blk, dly, toff} <= 4'h0;
    else if (wr6 && !(reg_req_i.remote && blk))
      {blk, dly, toff} <= {reg_req_i.wdata[2], reg_req_i.wdata[4:3],
        reg_req_i.wdata[0]};
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  property p_hit;
    reg_req_i.valid && reg_req_i.addr inside {8'h08, 8'h09}
      |=> reg_rsp_o.valid && reg_rsp_o.hit;
  endproperty
  a_hit: assert property (p_hit) else $error("entry not hit");
  property p_unmap;
    reg_req_i.valid && (reg_req_i.addr < 8'h06 || reg_req_i.addr > 8'h09)
      |=> reg_rsp_o.valid && !reg_rsp_o.hit && reg_rsp_o.rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped hit");
  property p_refuse;
    reg_req_i.valid && reg_req_i.write && reg_req_i.remote && blk
      |=> reg_rsp_o.refused;
  endproperty
  a_refuse: assert property (p_refuse) else $error("not refused");
  property p_accept;
    reg_req_i.valid && !reg_req_i.remote |=> !reg_rsp_o.refused;
  endproperty
  a_accept: assert property (p_accept) else $error("local refused");
  property p_route;
    host_addr_valid_i |=> route_o.valid;
  endproperty
  a_route: assert property (p_route) else $error("no route");
  // code 0 is seven edges from the sampling edge to the output flop
  property p_sda;
    $rose(sda_drive_i) && dly == 2'h0 |-> !sda_oe_o[*8] ##1 sda_oe_o;
  endproperty
  a_sda: assert property (p_sda) else $error("sda delay");
  property p_free;
    $rose(bus_free_o) |-> sda_i;
  endproperty
  a_free: assert property (p_free) else $error("free with sda low");
  property p_rec;
    $rose(bus_recover_o) |-> !sda_i ##[0:2] scl_oe_o;
  endproperty
  a_rec: assert property (p_rec) else $error("bad recovery");
  property p_off;
    toff && $past(toff, 2) |-> !bus_free_o && !bus_recover_o;
  endproperty
  a_off: assert property (p_off) else $error("timer not off");
  c_refused: cover property (reg_rsp_o.refused);
  c_recover: cover property ($rose(bus_recover_o));
  c_slave: cover property (route_o.valid && route_o.to_slave);
endmodule : ctrl_cfg_props

// ### verif/i2c_far_end.sv
`timescale 1ns/100ps
module i2c_far_end
(
  input wire logic scl_oe_i,
  input wire logic sda_oe_i,
  input wire logic host_clk_en_i,
  input wire logic host_sda_low_i,
  output logic scl_o,
  output logic sda_o
);
  logic host_scl = 1'b1;
  // host clock of 320 ns, parked high between frames
  always #160 host_scl = host_clk_en_i ? ~host_scl : 1'b1;
  // pull-ups: any party pulling low wins
  assign scl_o = !(scl_oe_i || !host_scl);
  assign sda_o = !(sda_oe_i || host_sda_low_i);
endmodule : i2c_far_end

// ### verif/tb.sv
`timescale 1ns/100ps
module tb;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  ctrl_channel_pkg::reg_req_s reg_req_i = '0;
  ctrl_channel_pkg::reg_rsp_s reg_rsp_o;
  ctrl_channel_pkg::route_s route_o;
  logic seq_err_evt_i = 1'b0;
  logic fwd_id_valid_i = 1'b0;
  logic [6:0] fwd_id_i = 7'h00;
  logic host_addr_valid_i = 1'b0;
  logic [6:0] host_addr_i = 7'h00;
  logic [6:0] match_alias_0_i = 7'h40;
  logic [6:0] match_alias_1_i = 7'h41;
  logic sda_drive_i = 1'b0;
  logic scl_i, sda_i, scl_o, scl_oe_o, sda_o, sda_oe_o;
  logic bus_free_o, bus_recover_o, p;
  logic host_clk_en = 1'b0;
  logic host_sda_low = 1'b0;
  int mismatches = 0;
  int compares = 0;
  int n, k;
  always #20 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////////
  // short watchdog periods keep the run small
  control_channel_i2c_config #(.WDOG_FAST_CYC(40), .WDOG_SLOW_CYC(100)) DUT
  (.mclk_i, .arst_n_i, .reg_req_i, .reg_rsp_o, .seq_err_evt_i,
   .fwd_id_valid_i, .fwd_id_i, .host_addr_valid_i, .host_addr_i,
   .match_alias_0_i, .match_alias_1_i, .route_o, .sda_drive_i, .scl_i,
   .sda_i, .scl_o, .scl_oe_o, .sda_o, .sda_oe_o, .bus_free_o,
   .bus_recover_o);
  i2c_far_end pins (.scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o),
    .host_clk_en_i(host_clk_en), .host_sda_low_i(host_sda_low),
    .scl_o(scl_i), .sda_o(sda_i));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  // one access; answer is read just after the answering edge
  task automatic acc(input logic w, r, input logic [7:0] a, d);
    @(posedge mclk_i);
    reg_req_i <= {1'b1, w, r, a, d};
    @(posedge mclk_i);
    reg_req_i.valid <= 1'b0;
    #1;
  endtask : acc
  task automatic rd(input logic [7:0] a, exp);
    acc(1'b0, 1'b0, a, 8'h00);
    chk({8'h00, reg_rsp_o.rdata}, {8'h00, exp});
  endtask : rd
  // strobes are {sequence error, forward address, host address}
  task automatic pulse(input logic [2:0] s);
    @(posedge mclk_i);
    {seq_err_evt_i, fwd_id_valid_i, host_addr_valid_i} <= s;
    @(posedge mclk_i);
    {seq_err_evt_i, fwd_id_valid_i, host_addr_valid_i} <= 3'h0;
  endtask : pulse
  task automatic route(input logic [6:0] a, input logic [9:0] exp);
    host_addr_i <= a;
    pulse(3'h1);
    #1;
    chk({route_o.valid, route_o.to_serializer, route_o.to_slave,
      route_o.slave_idx, route_o.addr}, {6'h01, exp});
  endtask : route
  task automatic wait_hi(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
  endtask : wait_hi
  // a host frame: the link clock runs, then parks
  task automatic frame;
    host_clk_en = 1'b1;
    repeat (32) @(posedge mclk_i);
    host_clk_en = 1'b0;
  endtask : frame
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #3000000;
    mismatches++;
    close_out();
  end
  initial
  begin
    repeat (12) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h18);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h00);
    rd(8'h0A, 8'h00);
    rd(8'h05, 8'h00);
    acc(1'b1, 1'b0, 8'h08, 8'hFF);
    rd(8'h08, 8'hFE);
    acc(1'b1, 1'b0, 8'h09, 8'hA5);
    rd(8'h09, 8'hA4);
    acc(1'b1, 1'b0, 8'h06, 8'h20);
    rd(8'h06, 8'h00);
    pulse(3'h4);
    rd(8'h06, 8'h80);
    acc(1'b1, 1'b0, 8'h06, 8'h40);
    rd(8'h06, 8'h40);
    acc(1'b1, 1'b0, 8'h06, 8'h00);
    rd(8'h06, 8'h00);
    fwd_id_i <= 7'h2A;
    pulse(3'h2);
    rd(8'h07, 8'h54);
    acc(1'b1, 1'b0, 8'h07, 8'h67);
    fwd_id_i <= 7'h11;
    pulse(3'h2);
    rd(8'h07, 8'h67);
    acc(1'b1, 1'b0, 8'h07, 8'h66);
    pulse(3'h2);
    rd(8'h07, 8'h22);
    acc(1'b1, 1'b0, 8'h06, 8'h04);
    acc(1'b1, 1'b1, 8'h08, 8'h55);
    chk(16'(reg_rsp_o.refused), 16'h1);
    rd(8'h08, 8'hFE);
    route(7'h40, {3'b010, 7'h7F});
    acc(1'b1, 1'b1, 8'h06, 8'h00);
    chk(16'(reg_rsp_o.refused), 16'h1);
    acc(1'b1, 1'b0, 8'h06, 8'h00);
    acc(1'b1, 1'b1, 8'h08, 8'h54);
    chk(16'(reg_rsp_o.refused), 16'h0);
    rd(8'h08, 8'h54);
    route(7'h41, {3'b011, 7'h52});
    route(7'h11, {3'b100, 7'h11});
    match_alias_0_i <= 7'h00;
    acc(1'b1, 1'b0, 8'h07, 8'h00);
    route(7'h00, {3'b000, 7'h00});
    // each code step must add exactly one cycle of delay
    for (k = 0; k < 4; k++)
    begin
      acc(1'b1, 1'b0, 8'h06, {3'b000, k[1:0], 3'b000});
      sda_drive_i <= 1'b1;
      wait_hi(sda_oe_o, 20);
      // one edge takes the input, then seven to ten edges of delay
      chk(16'(n), 16'(8 + k));
      sda_drive_i <= 1'b0;
      repeat (15) @(posedge mclk_i);
    end
    acc(1'b1, 1'b0, 8'h06, 8'h02);
    frame();
    chk(16'(bus_free_o), 16'h0);
    wait_hi(bus_free_o, 200);
    chk(16'(n >= 39 && n <= 44), 16'h1);
    acc(1'b1, 1'b0, 8'h06, 8'h00);
    frame();
    wait_hi(bus_free_o, 300);
    chk(16'(n >= 99 && n <= 104), 16'h1);
    acc(1'b1, 1'b0, 8'h06, 8'h01);
    frame();
    repeat (150) @(posedge mclk_i);
    chk(16'({bus_free_o, bus_recover_o}), 16'h0);
    host_sda_low <= 1'b1;
    acc(1'b1, 1'b0, 8'h06, 8'h02);
    wait_hi(bus_recover_o, 100);
    chk(16'(bus_recover_o), 16'h1);
    chk(16'({scl_o, sda_o}), 16'h0);
    k = 0;
    p = 1'b0;
    n = 0;
    while (bus_recover_o === 1'b1 && n < 3000)
    begin
      if (scl_oe_o === 1'b1 && p === 1'b0)
        k++;
      p = scl_oe_o;
      @(posedge mclk_i);
      #1;
      n++;
    end
    host_sda_low <= 1'b0;
    chk(16'(k), 16'h9);
    close_out();
  end
endmodule : tb
bind control_channel_i2c_config ctrl_cfg_props u_props
  (.mclk_i, .arst_n_i, .reg_req_i, .reg_rsp_o, .host_addr_valid_i,
   .route_o, .sda_drive_i, .sda_i, .scl_oe_o, .sda_oe_o, .bus_free_o,
   .bus_recover_o);
